/* File: cax_pkg.sv */
/*
 * Package for the codec auxiliary control registers: addresses, field
 * positions, reset values, tone frequencies and the register request type.
 * Assumes a 250 MHz system clock and an upstream serial control bus decoder.
 */
package cax_pkg;
   // ==========================================================
   // Clock
   localparam int unsigned CAX_CLK_HZ = 250_000_000;

   // ==========================================================
   // Register addresses
   localparam logic [2:0] CAX_ADDR_DRV_CTRL   = 3'h5; // regulator_driver_control
   localparam logic [2:0] CAX_ADDR_VAD_CTRL   = 3'h6; // voice_detect_control
   localparam logic [2:0] CAX_ADDR_VAD_STATUS = 3'h7; // voice_detect_status

   // ==========================================================
   // Field positions
   localparam int CAX_DRV_SRC_SEL_BIT = 7;
   localparam int CAX_REG2_PWR_BIT    = 5;
   localparam int CAX_REG1_PWR_BIT    = 4;
   localparam int CAX_DRV_ON_LSB      = 0;
   localparam int CAX_VAD_EN_BIT      = 7;
   localparam int CAX_VAD_THR_BIT     = 6;
   localparam int CAX_VAD_AUX_BIT     = 3;
   localparam int CAX_VAD_FLAG_BIT    = 7;
   localparam int CAX_NOISE_LSB       = 5;

   // ==========================================================
   // Reset values and writable masks
   localparam logic [7:0] CAX_DRV_CTRL_RST = 8'h00;
   localparam logic [7:0] CAX_VAD_CTRL_RST = 8'h00;
   localparam logic [7:0] CAX_DRV_CTRL_MSK = 8'hBF;
   localparam logic [7:0] CAX_VAD_CTRL_MSK = 8'hC8;

   // ==========================================================
   // Tone frequencies in Hz
   localparam int unsigned CAX_F_WARBLE_HZ = 8;
   localparam int unsigned CAX_F_2730_HZ = 2730;
   localparam int unsigned CAX_F_2500_HZ = 2500;
   localparam int unsigned CAX_F_2000_HZ = 2000;
   localparam int unsigned CAX_F_2667_HZ = 2667;
   localparam int unsigned CAX_F_1000_HZ = 1000;
   localparam int unsigned CAX_F_1333_HZ = 1333;
   localparam int unsigned CAX_F_400_HZ  = 400;
   localparam int unsigned CAX_F_440_HZ  = 440;
   localparam int unsigned CAX_F_480_HZ  = 480;
   localparam int unsigned CAX_F_667_HZ  = 667;
   localparam int unsigned CAX_F_800_HZ  = 800;
   localparam int unsigned CAX_F_1200_HZ = 1200;
   localparam int unsigned CAX_F_1300_HZ = 1300;
   localparam int unsigned CAX_F_1477_HZ = 1477;
   localparam int unsigned CAX_F_1633_HZ = 1633;
   localparam int unsigned CAX_F_2100_HZ = 2100;
   localparam int unsigned CAX_F_2400_HZ = 2400;
   localparam int unsigned CAX_F_2700_HZ = 2700;
   localparam int unsigned CAX_F_3000_HZ = 3000;

   // Phase increment of a 32-bit accumulator for a given frequency
   function automatic logic [31:0] cax_inc(input int unsigned hz);
      logic [63:0] p;
      p = (64'(hz) << 32) / 64'(CAX_CLK_HZ);
      return p[31:0];
   endfunction

   localparam logic [31:0] CAX_INC_WARBLE = cax_inc(CAX_F_WARBLE_HZ);

   // ==========================================================
   // Register request from the serial control bus decoder
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] data;
   } cax_req_t;

   // Decoded tone setting
   typedef struct packed {
      logic        valid;
      logic        warble;
      logic [31:0] inc_a;
      logic [31:0] inc_b;
   } cax_tone_t;
endpackage

/* File: cax_tone_gen.sv */
/*
 * Non-keypad tone generator: square wave from a phase accumulator, with an
 * 8 Hz warble between two frequencies. Assumes the enable, kind select and
 * code come from neighbouring registers in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module cax_tone_gen (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       enable,
   input  wire logic       kind_select,
   input  wire logic [4:0] code,
   output var  logic       tone_r
);
   // ==========================================================
   // Frequency table
   function automatic cax_pkg::cax_tone_t tone_decode(input logic [4:0] c);
      cax_pkg::cax_tone_t t;
      t = '0;
      t.valid = 1'b1;
      case (c)
         5'h00:
         begin
            t.warble = 1'b1;
            t.inc_a  = cax_pkg::cax_inc(cax_pkg::CAX_F_2730_HZ);
            t.inc_b  = cax_pkg::cax_inc(cax_pkg::CAX_F_2500_HZ); // [RULE3]
         end
         5'h01:
         begin
            t.warble = 1'b1;
            t.inc_a  = cax_pkg::cax_inc(cax_pkg::CAX_F_2000_HZ);
            t.inc_b  = cax_pkg::cax_inc(cax_pkg::CAX_F_2667_HZ); // [RULE3]
         end
         5'h02:
         begin
            t.warble = 1'b1;
            t.inc_a  = cax_pkg::cax_inc(cax_pkg::CAX_F_1000_HZ);
            t.inc_b  = cax_pkg::cax_inc(cax_pkg::CAX_F_1333_HZ); // [RULE3]
         end
         5'h09: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_400_HZ);   // [RULE4]
         5'h0A: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_440_HZ);
         5'h0B: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_480_HZ);
         5'h0D: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_667_HZ);
         5'h0E: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_800_HZ);
         5'h0F: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_1000_HZ);
         5'h10: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_1200_HZ);
         5'h11: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_1300_HZ);
         5'h13: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_1477_HZ);
         5'h14: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_1633_HZ);
         5'h15: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_2000_HZ);
         5'h16: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_2100_HZ);
         5'h18: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_2400_HZ);
         5'h1A: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_2500_HZ);
         5'h1D: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_2700_HZ);
         5'h1F: t.inc_a = cax_pkg::cax_inc(cax_pkg::CAX_F_3000_HZ); // [RULE4]
         default: t.valid = 1'b0; // Blank codes give silence
      endcase
      return t;
   endfunction

   cax_pkg::cax_tone_t set;
   logic               run;
   logic [31:0]        phase_r;
   logic [31:0]        phase_nxt;
   logic [31:0]        warble_r;
   logic [31:0]        warble_nxt;
   logic               tone_nxt;

   // Run only when enabled, other-tone table chosen and code defined
   assign set = tone_decode(code);
   assign run = enable && !kind_select && set.valid; // [RULE1] [RULE2]

   // Next phase of both accumulators
   always_comb
   begin
      phase_nxt  = '0;
      warble_nxt = '0;
      tone_nxt   = 1'b0;
      if (run)
      begin
         warble_nxt = warble_r + cax_pkg::CAX_INC_WARBLE;
         phase_nxt  = phase_r + ((set.warble && warble_r[31]) ? set.inc_b : set.inc_a); // [RULE3]
         tone_nxt   = phase_nxt[31];
      end
   end

   // Registers
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         phase_r  <= '0;
         warble_r <= '0;
         tone_r   <= 1'b0;
      end
      else
      begin
         phase_r  <= phase_nxt;
         warble_r <= warble_nxt;
         tone_r   <= tone_nxt;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   tone_off_idle_a: assert property (!enable |=> !tone_r && phase_r == '0) // [RULE2]
      else $error("tone active while generator disabled");
   keypad_table_quiet_a: assert property (kind_select |=> !tone_r) // [RULE1]
      else $error("other-tone output while keypad table selected");
   warble_step_a: assert property (run && set.warble && !warble_r[31] |=>
      phase_r == $past(phase_r) + $past(set.inc_a)) // [RULE3]
      else $error("warble first half uses wrong frequency");
endmodule
`default_nettype wire

/* File: cax_aux_regs.sv */
/*
 * Auxiliary control register bank of a voice codec: regulator power, four
 * open-drain drivers, voice activity detector control and its status, plus
 * the non-keypad tone generator. Assumes a serial control bus decoder that
 * hands over one-cycle read/write requests synchronous to clk.
 */
// Notes on behaviour
// [RULE1] Other-tone table only when kind select zero
// [RULE2] Tone generator runs only while enabled
// [RULE3] Codes 0-2 warble between two tones at 8 Hz
// [RULE4] Remaining listed codes give single fixed tones
// [RULE5] Host avoids blank tone codes
// [RULE6] Driver one follows its bit or receive sign
// [RULE7] Regulator two powered when its bit is one
// [RULE8] Regulator one powered when its bit is one
// [RULE9] System holds external power-down pins low
// [RULE10] Driver bits: zero floats, one pulls low
// [RULE11] Detector enable bit switches detection on/off
// [RULE12] Host sets bit three with detector enable
// [RULE13] Threshold bit picks -26 or -38 dBm0
// [RULE14] Host writes zero to unused bits
// [RULE15] Status top bit reports voice versus silence
// [RULE16] Two-bit noise level indicator in status
// [RULE17] Status valid only while detector enabled
// [RULE18] Status low five bits are test only
`timescale 1ns/1ps
`default_nettype none
module cax_aux_regs (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire cax_pkg::cax_req_t req,
   output var  logic [7:0]        rdata_r,
   output var  logic              rvalid_r,
   input  wire logic              rx_sign,
   input  wire logic              tone_enable,
   input  wire logic              tone_kind_select,
   input  wire logic [4:0]        tone_code,
   output var  logic              tone_out_r,
   input  wire logic              vad_voice_in,
   input  wire logic [1:0]        vad_noise_in,
   output var  logic              vad_enable_r,
   output var  logic              vad_threshold_select_r,
   output var  logic              regulator_one_power_r,
   output var  logic              regulator_two_power_r,
   output var  logic [3:0]        drv_out_r,
   output var  logic [3:0]        drv_oe_n_r
);
   // ==========================================================
   // Declarations
   logic [7:0] drv_ctrl_r;
   logic [7:0] drv_ctrl_nxt;
   logic [7:0] vad_ctrl_r;
   logic [7:0] vad_ctrl_nxt;
   logic [7:0] status_r;
   logic [7:0] status_nxt;
   logic [7:0] rdata_nxt;
   logic       rvalid_nxt;
   logic [3:0] drv_oe_n_nxt;

   // Read value of an address, unmapped reads give zero
   function automatic logic [7:0] read_mux(input logic [2:0] a, input logic [7:0] d,
                                           input logic [7:0] v, input logic [7:0] s);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         cax_pkg::CAX_ADDR_DRV_CTRL:   r = d;
         cax_pkg::CAX_ADDR_VAD_CTRL:   r = v;
         cax_pkg::CAX_ADDR_VAD_STATUS: r = s;
         default:                      r = 8'h00;
      endcase
      return r;
   endfunction

   // ==========================================================
   // Control registers: only implemented bits are stored
   always_comb
   begin
      drv_ctrl_nxt = drv_ctrl_r;
      vad_ctrl_nxt = vad_ctrl_r;
      if (req.wr && req.addr == cax_pkg::CAX_ADDR_DRV_CTRL)
      begin
         drv_ctrl_nxt = req.data & cax_pkg::CAX_DRV_CTRL_MSK;
      end
      if (req.wr && req.addr == cax_pkg::CAX_ADDR_VAD_CTRL)
      begin
         vad_ctrl_nxt = req.data & cax_pkg::CAX_VAD_CTRL_MSK;
      end
   end

   // ==========================================================
   // Detect status: voice flag and noise level, zero while detector off
   always_comb
   begin
      status_nxt = 8'h00; // Test bits read as zero [RULE18]
      if (vad_ctrl_r[cax_pkg::CAX_VAD_EN_BIT])
      begin
         status_nxt[cax_pkg::CAX_VAD_FLAG_BIT] = vad_voice_in;              // [RULE15] [RULE17]
         status_nxt[cax_pkg::CAX_NOISE_LSB +: 2] = vad_noise_in;            // [RULE16] [RULE17]
      end
   end

   // ==========================================================
   // Read port: data one cycle after the request
   always_comb
   begin
      rvalid_nxt = req.rd;
      rdata_nxt  = 8'h00;
      if (req.rd)
      begin
         rdata_nxt = read_mux(req.addr, drv_ctrl_r, vad_ctrl_r, status_r);
      end
   end

   // ==========================================================
   // Driver enables: low while the pin is pulled low
   always_comb
   begin
      drv_oe_n_nxt = ~drv_ctrl_nxt[cax_pkg::CAX_DRV_ON_LSB +: 4]; // [RULE10]
      if (drv_ctrl_nxt[cax_pkg::CAX_DRV_SRC_SEL_BIT])
      begin
         drv_oe_n_nxt[0] = ~rx_sign; // [RULE6]
      end
   end

   // ==========================================================
   // Register stage
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         drv_ctrl_r             <= cax_pkg::CAX_DRV_CTRL_RST;
         vad_ctrl_r             <= cax_pkg::CAX_VAD_CTRL_RST;
         status_r               <= 8'h00;
         rdata_r                <= 8'h00;
         rvalid_r               <= 1'b0;
         drv_oe_n_r             <= 4'hF;
         drv_out_r              <= 4'h0;
         regulator_one_power_r  <= 1'b0;
         regulator_two_power_r  <= 1'b0;
         vad_enable_r           <= 1'b0;
         vad_threshold_select_r <= 1'b0;
      end
      else
      begin
         drv_ctrl_r             <= drv_ctrl_nxt;
         vad_ctrl_r             <= vad_ctrl_nxt;
         status_r               <= status_nxt;
         rdata_r                <= rdata_nxt;
         rvalid_r               <= rvalid_nxt;
         drv_oe_n_r             <= drv_oe_n_nxt;
         drv_out_r              <= 4'h0;                                                  // Open drain low
         regulator_one_power_r  <= drv_ctrl_nxt[cax_pkg::CAX_REG1_PWR_BIT];              // [RULE8]
         regulator_two_power_r  <= drv_ctrl_nxt[cax_pkg::CAX_REG2_PWR_BIT];              // [RULE7]
         vad_enable_r           <= vad_ctrl_nxt[cax_pkg::CAX_VAD_EN_BIT];                // [RULE11]
         vad_threshold_select_r <= vad_ctrl_nxt[cax_pkg::CAX_VAD_THR_BIT];               // [RULE13]
      end
   end

   // ==========================================================
   // Tone generator
   cax_tone_gen u_tone (
      .clk         (clk),
      .reset_n     (reset_n),
      .enable      (tone_enable),
      .kind_select (tone_kind_select),
      .code        (tone_code),
      .tone_r      (tone_out_r)
   );

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence drv_write_s;
      req.wr && req.addr == cax_pkg::CAX_ADDR_DRV_CTRL;
   endsequence

   sequence vad_write_s;
      req.wr && req.addr == cax_pkg::CAX_ADDR_VAD_CTRL;
   endsequence

   reg_two_power_a: assert property (drv_write_s |=> regulator_two_power_r == $past(req.data[5])) // [RULE7]
      else $error("regulator two power does not follow write");
   reg_one_power_a: assert property (drv_write_s |=> regulator_one_power_r == $past(req.data[4])) // [RULE8]
      else $error("regulator one power does not follow write");
   driver_bits_a: assert property (drv_write_s |=> drv_oe_n_r[3:1] == ~$past(req.data[3:1])
      && drv_out_r == 4'h0) // [RULE10]
      else $error("driver enables do not follow control bits");
   driver_one_src_a: assert property (drv_ctrl_r[7] |=> drv_oe_n_r[0] == !$past(rx_sign)
      || $past(req.wr)) // [RULE6]
      else $error("driver one does not follow receive sign");
   driver_one_own_a: assert property (!drv_ctrl_r[7] && !req.wr |=> drv_oe_n_r[0] == !$past(drv_ctrl_r[0])) // [RULE6]
      else $error("driver one does not follow its control bit");
   vad_enable_a: assert property (vad_write_s |=> vad_enable_r == $past(req.data[7])
      && vad_threshold_select_r == $past(req.data[6])) // [RULE11] [RULE13]
      else $error("detector controls do not follow write");
   status_gate_a: assert property (!vad_ctrl_r[7] |=> status_r == 8'h00) // [RULE17]
      else $error("status not cleared while detector off");
   status_voice_a: assert property (vad_ctrl_r[7] |=> status_r[7] == $past(vad_voice_in)
      && status_r[6:5] == $past(vad_noise_in) && status_r[4:0] == 5'h00) // [RULE15] [RULE16] [RULE18]
      else $error("status does not report detector result");
   read_return_a: assert property (req.rd && req.addr == cax_pkg::CAX_ADDR_VAD_CTRL && !req.wr
      |=> rvalid_r && rdata_r == $past(vad_ctrl_r) ##1 !rvalid_r || $past(req.rd)) // [RULE11]
      else $error("read of detector control wrong");
endmodule
`default_nettype wire

/* File: cax_host_model.sv */
/*
 * Host model for the auxiliary register bank: issues one-cycle write and read
 * requests, launched on the falling edge of clk.
 * Assumes the bank takes req on the rising edge and answers a read one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module cax_host_model (
   input  wire logic              clk,
   input  wire logic [7:0]        rdata_r,
   input  wire logic              rvalid_r,
   output var  cax_pkg::cax_req_t req
);
   // ==========================================================
   // Idle bus at time zero
   initial
   begin
      req = '0;
   end

   // ==========================================================
   // Write one byte, unused bits cleared, bit three tied to detector enable
   task automatic write_reg(input logic [2:0] addr, input logic [7:0] data);
      logic [7:0] d;
      d = data;
      if (addr == cax_pkg::CAX_ADDR_DRV_CTRL)
         d = data & cax_pkg::CAX_DRV_CTRL_MSK;
      if (addr == cax_pkg::CAX_ADDR_VAD_CTRL)
         d = {data[7:6], 2'h0, data[7], 3'h0};
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: addr, data: d};
      @(negedge clk);
      req = '0;
   endtask

   // Read one byte; the answer is picked up in the cycle after the taking edge
   task automatic read_reg(input logic [2:0] addr, output logic [7:0] data, output logic valid);
      @(negedge clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: addr, data: 8'h00};
      @(negedge clk);
      req   = '0;
      data  = rdata_r;
      valid = rvalid_r;
   endtask
endmodule
`default_nettype wire

/* File: cax_aux_regs_test.sv */
/*
 * Self-checking bench for the auxiliary register bank: reset values, register
 * access, driver and regulator steering, detector status and two tone codes.
 * Assumes the host model drives the register requests.
 */
`timescale 1ns/1ps
`default_nettype none
module cax_aux_regs_test;
   logic              clk, reset_n, rx_sign, tone_enable, tone_kind_select, vad_voice_in;
   logic [4:0]        tone_code;
   logic [1:0]        vad_noise_in;
   cax_pkg::cax_req_t req;
   logic [7:0]        rdata_r, rd, c;
   logic              rvalid_r, ok, tone_out_r, vad_enable_r, vad_threshold_select_r;
   logic              regulator_one_power_r, regulator_two_power_r;
   logic [3:0]        drv_out_r, drv_oe_n_r;
   int                failures, samples_checked;
   longint            inc, n;

   // ==========================================================
   // Design and host
   cax_aux_regs cax_aux_regs_i (.clk(clk), .reset_n(reset_n), .req(req), .rdata_r(rdata_r),
      .rvalid_r(rvalid_r), .rx_sign(rx_sign), .tone_enable(tone_enable),
      .tone_kind_select(tone_kind_select), .tone_code(tone_code), .tone_out_r(tone_out_r),
      .vad_voice_in(vad_voice_in), .vad_noise_in(vad_noise_in), .vad_enable_r(vad_enable_r),
      .vad_threshold_select_r(vad_threshold_select_r), .regulator_one_power_r(regulator_one_power_r),
      .regulator_two_power_r(regulator_two_power_r), .drv_out_r(drv_out_r), .drv_oe_n_r(drv_oe_n_r));
   cax_host_model cax_host_model_i (.clk(clk), .rdata_r(rdata_r), .rvalid_r(rvalid_r), .req(req));

   // ==========================================================
   // Checking helpers
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Driver enables: low pulls the pin, driver one may follow the receive sign
   function automatic logic [3:0] exp_oe(input logic [7:0] v, input logic s);
      return {~v[3:1], v[7] ? ~s : ~v[0]};
   endfunction

   // Status byte as read: flag and noise level only while the detector runs
   function automatic logic [7:0] exp_status(input logic en, input logic v, input logic [1:0] nz);
      return en ? {v, nz, 5'h00} : 8'h00;
   endfunction

   task automatic read_check(input string name, input logic [2:0] a, input logic [7:0] exp);
      cax_host_model_i.read_reg(a, rd, ok);
      check({name, " valid"}, 8'(ok), 8'h01);
      check(name, rd, exp);
   endtask

   task automatic give_verdict;
      if (failures == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ==========================================================
   // Clock and watchdog
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      failures++;
      give_verdict();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      reset_n = 1'b0; rx_sign = 1'b0; tone_enable = 1'b0; tone_kind_select = 1'b0;
      tone_code = 5'h1F; vad_voice_in = 1'b0; vad_noise_in = 2'h0; // Listed codes only
      failures = 0; samples_checked = 0;
      void'($urandom(76));
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      // Reset state and reads of all eight addresses
      check("oe reset", 8'(drv_oe_n_r), 8'h0F);
      check("pwr reset", 8'({regulator_two_power_r, regulator_one_power_r}), 8'h00);
      check("vad reset", 8'({vad_enable_r, vad_threshold_select_r}), 8'h00);
      check("tone reset", 8'(tone_out_r), 8'h00);
      for (int a = 0; a < 8; a++)
         read_check("reset read", 3'(a), 8'h00);
      // Driver and regulator control, corners first
      for (int i = 0; i < 24; i++)
      begin
         c = (i == 0) ? 8'h80 : (i == 1) ? 8'hBF : (i == 2) ? 8'h0F : 8'($urandom);
         rx_sign = 1'($urandom);
         cax_host_model_i.write_reg(cax_pkg::CAX_ADDR_DRV_CTRL, c);
         c = c & 8'hBF;
         check("reg two", 8'(regulator_two_power_r), 8'(c[5]));
         check("reg one", 8'(regulator_one_power_r), 8'(c[4]));
         check("oe", 8'(drv_oe_n_r), 8'(exp_oe(c, rx_sign)));
         check("drv out", 8'(drv_out_r), 8'h00);
         rx_sign = ~rx_sign;
         @(negedge clk);
         check("oe sign", 8'(drv_oe_n_r), 8'(exp_oe(c, rx_sign)));
         read_check("drv read", cax_pkg::CAX_ADDR_DRV_CTRL, c);
      end
      // Writes to the status and an unmapped place change nothing
      cax_host_model_i.write_reg(cax_pkg::CAX_ADDR_VAD_STATUS, 8'hFF);
      cax_host_model_i.write_reg(3'h2, 8'hFF);
      read_check("drv kept", cax_pkg::CAX_ADDR_DRV_CTRL, c);
      read_check("status ro", cax_pkg::CAX_ADDR_VAD_STATUS, 8'h00);
      // Detector control and status
      for (int i = 0; i < 16; i++)
      begin
         c = (i == 0) ? 8'hC0 : (i == 1) ? 8'h40 : 8'($urandom);
         cax_host_model_i.write_reg(cax_pkg::CAX_ADDR_VAD_CTRL, c);
         check("vad en", 8'(vad_enable_r), 8'(c[7]));
         check("vad thr", 8'(vad_threshold_select_r), 8'(c[6]));
         read_check("vad read", cax_pkg::CAX_ADDR_VAD_CTRL, {c[7:6], 2'h0, c[7], 3'h0});
         vad_voice_in = 1'($urandom);
         vad_noise_in = 2'($urandom);
         repeat (3) @(negedge clk);
         read_check("status", cax_pkg::CAX_ADDR_VAD_STATUS,
            exp_status(c[7], vad_voice_in, vad_noise_in));
      end
      // Warble code: first half runs on the higher tone, output still low
      tone_code = 5'h00; // Listed warble code
      tone_enable = 1'b1;
      repeat (200) @(negedge clk);
      check("tone warble", 8'(tone_out_r), 8'h00);
      tone_enable = 1'b0;
      tone_code = 5'h1F;
      repeat (2) @(negedge clk);
      // Single 3000 Hz tone: first rise of the square wave
      inc = (longint'(cax_pkg::CAX_F_3000_HZ) << 32) / longint'(cax_pkg::CAX_CLK_HZ);
      n = ((longint'(1) << 31) + inc - 1) / inc;
      tone_enable = 1'b1;
      repeat (n - 8) @(negedge clk);
      check("tone low", 8'(tone_out_r), 8'h00);
      repeat (16) @(negedge clk);
      check("tone high", 8'(tone_out_r), 8'h01);
      tone_kind_select = 1'b1;
      repeat (3) @(negedge clk);
      check("tone keypad", 8'(tone_out_r), 8'h00);
      tone_kind_select = 1'b0;
      tone_enable = 1'b0;
      repeat (3) @(negedge clk);
      check("tone off", 8'(tone_out_r), 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
